// *** design/csx_range_match.sv ***
// masked compare of an address field against a programmed base
// assumes base and mask are already aligned by the caller
`timescale 1ns/1ps
`default_nettype none
module csx_range_match #(
  parameter int W = 10
) (
  input  wire logic [W-1:0] addrField,
  input  wire logic [W-1:0] baseField,
  input  wire logic [W-1:0] maskField,
  output logic              hit
);

  // bits under the mask must equal the base, the rest are don't care
  assign hit = (((addrField ^ baseField) & maskField) == '0);

endmodule
`default_nettype wire

// *** design/csx_strap_capture.sv ***
// test-mode strap capture at the rising edge of the reset pin
// assumes resetInN is synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module csx_strap_capture (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic resetInN,
  input  wire logic lowerPinIn,
  input  wire logic upperPinIn,
  output logic      onceMode
);

  logic resetPrev_q;
  logic onceMode_q;
  logic onceMode_d;
  wire  resetRise = resetInN & ~resetPrev_q;

  // both selects low at release enters test mode; reset pin low leaves it
  assign onceMode_d = ~resetInN ? 1'b0
                    : resetRise ? (~lowerPinIn & ~upperPinIn)
                    : onceMode_q;
  assign onceMode = onceMode_q;

  // previous reset level doubles as the edge detector
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resetPrev_q <= 1'b0;
      onceMode_q  <= 1'b0;
    end else begin
      resetPrev_q <= resetInN;
      onceMode_q  <= onceMode_d;
    end
  end

endmodule
`default_nettype wire

// *** design/csx_top.sv ***
// chip select, coprocessor handshake and transceiver control outputs
// assumes bus cycle signals come from the sequencer, synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module csx_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        resetInN,
  // bus cycle from the sequencer
  input  wire logic        busActive,
  input  wire logic        busIsMem,
  input  wire logic        busIsIo,
  input  wire logic        busWrite,
  input  wire logic        busCoproc,
  input  wire logic [19:0] busAddr,
  input  wire logic        holdGranted,
  // configuration load
  input  wire logic        cfgLoad,
  input  wire logic [3:0]  cfgLowerSize,
  input  wire logic [3:0]  cfgUpperSize,
  input  wire logic [6:0]  cfgMidBase,
  input  wire logic [2:0]  cfgMidSize,
  input  wire logic [9:0]  cfgPeriphBase,
  input  wire logic        cfgPeriphInMem,
  input  wire logic        cfgSel5Latched,
  input  wire logic        cfgSel6Latched,
  input  wire logic        cfgEnhanced,
  // memory select pins
  input  wire logic        lowerMemSelectNIn,
  output logic             lowerMemSelectNOut,
  output logic             lowerMemSelectNOe,
  input  wire logic        upperMemSelectNIn,
  output logic             upperMemSelectNOut,
  output logic             upperMemSelectNOe,
  input  wire logic [3:0]  midMemSelectNIn,
  output logic [3:0]       midMemSelectNOut,
  output logic [3:0]       midMemSelectNOe,
  // peripheral select pins, 5 and 6 double as latched address bits
  output logic [4:0]       periphSelectNOut,
  output logic [4:0]       periphSelectNOe,
  output logic             periphSel5OrAddrBit1Out,
  output logic             periphSel5OrAddrBit1Oe,
  output logic             periphSel6OrAddrBit2Out,
  output logic             periphSel6OrAddrBit2Oe,
  // transceiver controls
  output logic             xcvrDirectionOut,
  output logic             xcvrDirectionOe,
  output logic             xcvrEnableNOut,
  output logic             xcvrEnableNOe,
  // coprocessor handshake seen by the core
  output logic             coprocXferRequest,
  output logic             coprocError,
  output logic             onceModeActive
);

  // configuration storage
  logic [3:0] lowCode_q;
  logic [3:0] upCode_q;
  logic [6:0] midBase_q;
  logic [2:0] midCode_q;
  logic [9:0] perBase_q;
  logic       perMem_q;
  logic       sel5Latch_q;
  logic       sel6Latch_q;
  logic       enhanced_q;

  // pin state
  logic       lowOut_q, lowOe_q, upOut_q, upOe_q;
  logic [3:0] midOut_q, midOe_q;
  logic [6:0] perOut_q, perOe_q;
  logic       dirOut_q, dirOe_q, enOut_q, enOe_q;
  logic [1:0] addrLatch_q;
  logic       xferReq_q, coErr_q;
  logic       resetSeen_q;
  csx_pkg::csx_rst_t rstState_q, rstState_d;

  logic [3:0] midOut_d, midOe_d;
  logic [6:0] perOut_d;
  logic       dirOut_d, enOut_d;
  logic [1:0] addrLatch_d;

  wire onceMode;

  // config held in storage, reloaded by software, defaulted by the reset pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lowCode_q   <= csx_pkg::LOW_CODE_RST;
      upCode_q    <= csx_pkg::UP_CODE_RST;
      midBase_q   <= csx_pkg::MID_BASE_RST;
      midCode_q   <= csx_pkg::MID_CODE_RST;
      perBase_q   <= csx_pkg::PER_BASE_RST;
      perMem_q    <= csx_pkg::PER_MEM_RST;
      sel5Latch_q <= csx_pkg::PER_LATCH_RST;
      sel6Latch_q <= csx_pkg::PER_LATCH_RST;
      enhanced_q  <= csx_pkg::ENHANCED_RST;
    end else if (!resetInN) begin
      lowCode_q   <= csx_pkg::LOW_CODE_RST;
      upCode_q    <= csx_pkg::UP_CODE_RST;
      midBase_q   <= csx_pkg::MID_BASE_RST;
      midCode_q   <= csx_pkg::MID_CODE_RST;
      perBase_q   <= csx_pkg::PER_BASE_RST;
      perMem_q    <= csx_pkg::PER_MEM_RST;
      sel5Latch_q <= csx_pkg::PER_LATCH_RST;
      sel6Latch_q <= csx_pkg::PER_LATCH_RST;
      enhanced_q  <= csx_pkg::ENHANCED_RST;
    end else if (cfgLoad) begin
      lowCode_q   <= cfgLowerSize;
      upCode_q    <= cfgUpperSize;
      midBase_q   <= cfgMidBase;
      midCode_q   <= cfgMidSize;
      perBase_q   <= cfgPeriphBase;
      perMem_q    <= cfgPeriphInMem;
      sel5Latch_q <= cfgSel5Latched;
      sel6Latch_q <= cfgSel6Latched;
      enhanced_q  <= cfgEnhanced;
    end
  end

  // size codes past the largest block clamp to it
  wire [3:0] lowCodeC = (lowCode_q > csx_pkg::LOW_UP_CODE_MAX) ? csx_pkg::LOW_UP_CODE_MAX
                                                               : lowCode_q;
  wire [3:0] upCodeC  = (upCode_q > csx_pkg::LOW_UP_CODE_MAX) ? csx_pkg::LOW_UP_CODE_MAX
                                                              : upCode_q;
  wire [2:0] midCodeC = (midCode_q > csx_pkg::MID_CODE_MAX) ? csx_pkg::MID_CODE_MAX
                                                            : midCode_q;

  // region masks on kilobyte and 8K granules
  wire [9:0] lowMask = 10'h3ff << lowCodeC;
  wire [9:0] upMask  = 10'h3ff << upCodeC;
  wire [6:0] midMask = 7'h7f << midCodeC;
  wire [9:0] perMask = perMem_q ? 10'h3ff : 10'h03f; // I/O space ignores bits 19..16

  wire [9:0] addrKb  = busAddr[19:csx_pkg::KB_SHIFT];
  wire [6:0] addrMid = busAddr[19:csx_pkg::MID_SHIFT];
  wire lowHit, upHit, midHit, perHit;

  // lower region starts at address zero
  csx_range_match #(.W(csx_pkg::KB_W)) uLow (
    .addrField (addrKb),
    .baseField (10'h000),
    .maskField (lowMask),
    .hit       (lowHit)
  );

  // upper block ends at the top of memory
  csx_range_match #(.W(csx_pkg::KB_W)) uUp (
    .addrField (addrKb),
    .baseField (10'h3ff),
    .maskField (upMask),
    .hit       (upHit)
  );

  // mid region base is aligned to its own size
  csx_range_match #(.W(csx_pkg::MID_W)) uMid (
    .addrField (addrMid),
    .baseField (midBase_q),
    .maskField (midMask),
    .hit       (midHit)
  );

  csx_range_match #(.W(csx_pkg::KB_W)) uPer (
    .addrField (addrKb),
    .baseField (perBase_q),
    .maskField (perMask),
    .hit       (perHit)
  );

  csx_strap_capture uStrap (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .resetInN   (resetInN),
    .lowerPinIn (lowerMemSelectNIn),
    .upperPinIn (upperMemSelectNIn),
    .onceMode   (onceMode)
  );

  // access qualifiers; coprocessor cycles hit no memory or peripheral select
  wire run      = resetInN & resetSeen_q & ~onceMode; // release edge floats, straps judged there
  wire access   = busActive & ~holdGranted;
  wire memAcc   = access & busIsMem & ~busCoproc;
  wire perAcc   = access & ~busCoproc & (perMem_q ? busIsMem : busIsIo);
  wire [19:0] midShift = busAddr >> (5'(csx_pkg::MID_SUB_SH) + 5'(midCodeC));
  wire [1:0]  midIdx   = midShift[1:0];
  wire [2:0]  perIdx   = busAddr[csx_pkg::PER_BLK_SH +: 3];

  // mid selects split the region in quarters; enhanced mode repurposes 0, 1, 3
  generate
    for (genvar i = 0; i < csx_pkg::MID_N; i++) begin : gMid
      wire midSel = memAcc & midHit & (midIdx == 2'(i));
      if (i == 3) begin : gNps
        assign midOut_d[i] = enhanced_q ? ~(access & busCoproc)
                                        : ~midSel;
        assign midOe_d[i]  = run;
      end else if (i < 2) begin : gIn
        assign midOut_d[i] = ~midSel;
        assign midOe_d[i]  = run & ~enhanced_q;
      end else begin : gPlain
        assign midOut_d[i] = ~midSel;
        assign midOe_d[i]  = run;
      end
    end
  endgenerate

  // peripheral selects, 128-byte blocks above the programmed base
  generate
    for (genvar i = 0; i < csx_pkg::PER_N; i++) begin : gPer
      wire perSel = perAcc & perHit & (perIdx == 3'(i));
      if (i == 5) begin : gA1
        assign perOut_d[i] = sel5Latch_q ? addrLatch_d[0] : ~perSel;
      end else if (i == 6) begin : gA2
        assign perOut_d[i] = sel6Latch_q ? addrLatch_d[1] : ~perSel;
      end else begin : gCs
        assign perOut_d[i] = ~perSel;
      end
    end
  endgenerate

  // address copy only updates on our own cycles, so hold keeps the old value
  assign addrLatch_d = access ? busAddr[2:1] : addrLatch_q;

  // direction follows the access; idle keeps the last direction
  assign dirOut_d = access ? busWrite : dirOut_q;
  wire   dirFlip  = dirOut_d != dirOut_q;
  // enable waits one cycle whenever the direction moves
  assign enOut_d  = ~(access & ~dirFlip);

  // enable sequence while the reset pin is low
  always_comb begin
    rstState_d = csx_pkg::RST_RUN;
    unique case (rstState_q)
      csx_pkg::RST_RUN:   rstState_d = resetInN ? csx_pkg::RST_RUN : csx_pkg::RST_DRIVE;
      csx_pkg::RST_DRIVE: rstState_d = resetInN ? csx_pkg::RST_RUN : csx_pkg::RST_FLOAT;
      csx_pkg::RST_FLOAT: rstState_d = resetInN ? csx_pkg::RST_RUN : csx_pkg::RST_FLOAT;
      default:            rstState_d = csx_pkg::RST_RUN;
    endcase
  end

  // memory and peripheral select pins; hold does not float them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lowOut_q <= 1'b1;
      lowOe_q  <= 1'b0;
      upOut_q  <= 1'b1;
      upOe_q   <= 1'b0;
      midOut_q <= 4'hf;
      midOe_q  <= 4'h0;
      perOut_q <= 7'h7f;
      perOe_q  <= 7'h00;
    end else begin
      lowOut_q <= ~(memAcc & lowHit);
      lowOe_q  <= run;
      upOut_q  <= ~(memAcc & upHit);
      upOe_q   <= run;
      midOut_q <= midOut_d;
      midOe_q  <= midOe_d;
      perOut_q <= perOut_d;
      perOe_q  <= {7{run}};
    end
  end

  // transceiver controls and latched address
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dirOut_q    <= 1'b0;
      dirOe_q     <= 1'b0;
      enOut_q     <= 1'b1;
      enOe_q      <= 1'b0;
      addrLatch_q <= 2'h0;
      rstState_q  <= csx_pkg::RST_RUN;
      resetSeen_q <= 1'b0;
    end else begin
      dirOut_q    <= dirOut_d;
      dirOe_q     <= run & ~holdGranted;
      enOut_q     <= resetInN ? enOut_d : 1'b1;
      enOe_q      <= run ? ~holdGranted : (rstState_d == csx_pkg::RST_DRIVE);
      addrLatch_q <= addrLatch_d;
      rstState_q  <= rstState_d;
      resetSeen_q <= resetInN;
    end
  end

  // coprocessor handshake inputs are only meaningful in enhanced mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xferReq_q <= 1'b0;
      coErr_q   <= 1'b0;
    end else begin
      xferReq_q <= enhanced_q & midMemSelectNIn[0];
      coErr_q   <= enhanced_q & ~midMemSelectNIn[1];
    end
  end

  assign lowerMemSelectNOut      = lowOut_q;
  assign lowerMemSelectNOe       = lowOe_q;
  assign upperMemSelectNOut      = upOut_q;
  assign upperMemSelectNOe       = upOe_q;
  assign midMemSelectNOut        = midOut_q;
  assign midMemSelectNOe         = midOe_q;
  assign periphSelectNOut        = perOut_q[4:0];
  assign periphSelectNOe         = perOe_q[4:0];
  assign periphSel5OrAddrBit1Out = perOut_q[5];
  assign periphSel5OrAddrBit1Oe  = perOe_q[5];
  assign periphSel6OrAddrBit2Out = perOut_q[6];
  assign periphSel6OrAddrBit2Oe  = perOe_q[6];
  assign xcvrDirectionOut        = dirOut_q;
  assign xcvrDirectionOe         = dirOe_q;
  assign xcvrEnableNOut          = enOut_q;
  assign xcvrEnableNOe           = enOe_q;
  assign coprocXferRequest       = xferReq_q;
  assign coprocError             = coErr_q;
  assign onceModeActive          = onceMode;

endmodule
`default_nettype wire

// *** dv/csx_far_side.sv ***
// far side of the memory select pins: pull-ups, strap resistors, coprocessor
// assumes the bench reads the pins only through these levels
`timescale 1ns/1ps
`default_nettype none
module csx_far_side (
  input wire logic       strapLow,
  input wire logic       coprocReqLvl,
  input wire logic       coprocErrN,
  input wire logic       lowerOut,
  input wire logic       lowerOe,
  input wire logic       upperOut,
  input wire logic       upperOe,
  input wire logic [3:0] midOut,
  input wire logic [3:0] midOe,
  output logic           lowerPin,
  output logic           upperPin,
  output logic [3:0]     midPin
);
  // released selects rest on pull-ups unless the strap resistors win
  assign lowerPin = lowerOe ? lowerOut : !strapLow;
  assign upperPin = upperOe ? upperOut : !strapLow;
  // coprocessor only drives request and error once the device lets go
  assign midPin[0] = midOe[0] ? midOut[0] : coprocReqLvl;
  assign midPin[1] = midOe[1] ? midOut[1] : coprocErrN;
  assign midPin[3:2] = (midOe[3:2] & midOut[3:2]) | ~midOe[3:2];
endmodule
`default_nettype wire

// *** dv/csx_top_props.sv ***
// assertions on the select, strap and transceiver pins of csx_top
// assumes it is bound into csx_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module csx_top_props (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       resetInN,
  input wire logic       busActive,
  input wire logic       busIsMem,
  input wire logic       busWrite,
  input wire logic       busCoproc,
  input wire logic       holdGranted,
  input wire logic       lowerMemSelectNIn,
  input wire logic       upperMemSelectNIn,
  input wire logic       lowerMemSelectNOut,
  input wire logic       lowerMemSelectNOe,
  input wire logic       upperMemSelectNOe,
  input wire logic [3:0] midMemSelectNOut,
  input wire logic [3:0] midMemSelectNOe,
  input wire logic [4:0] periphSelectNOe,
  input wire logic       periphSel5OrAddrBit1Oe,
  input wire logic       periphSel6OrAddrBit2Oe,
  input wire logic       xcvrDirectionOut,
  input wire logic       xcvrDirectionOe,
  input wire logic       xcvrEnableNOut,
  input wire logic       xcvrEnableNOe,
  input wire logic       onceModeActive
);
  // edges of normal running since release; pin enables only rise on the second one
  logic [1:0] runCnt_q;
  logic       runOk;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      runCnt_q <= 2'h0;
    end else if (!resetInN || onceModeActive) begin
      runCnt_q <= 2'h0;
    end else if (runCnt_q != 2'h3) begin
      runCnt_q <= runCnt_q + 2'h1;
    end
  end
  assign runOk = (runCnt_q == 2'h3) && resetInN;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_hold_driven; runOk && holdGranted |=> lowerMemSelectNOe && upperMemSelectNOe
    && (&periphSelectNOe) && periphSel5OrAddrBit1Oe && periphSel6OrAddrBit2Oe; endproperty
  a_hold_driven: assert property (p_hold_driven) else $error("select floated in hold");
  property p_hold_float; holdGranted && resetInN |=> !xcvrDirectionOe && !xcvrEnableNOe; endproperty
  a_hold_float: assert property (p_hold_float) else $error("transceiver driven in hold");
  property p_rst_en; $fell(resetInN) ##1 !resetInN |-> xcvrEnableNOe && xcvrEnableNOut
    ##1 !xcvrEnableNOe && !xcvrDirectionOe; endproperty
  a_rst_en: assert property (p_rst_en) else $error("enable reset pulse wrong");
  property p_strap; $rose(resetInN) |=>
    onceModeActive == $past(!lowerMemSelectNIn && !upperMemSelectNIn); endproperty
  a_strap: assert property (p_strap) else $error("strap sample wrong");
  property p_once_float; onceModeActive |-> !(lowerMemSelectNOe || upperMemSelectNOe
    || (|midMemSelectNOe) || (|periphSelectNOe) || periphSel5OrAddrBit1Oe
    || periphSel6OrAddrBit2Oe || xcvrDirectionOe || xcvrEnableNOe); endproperty
  a_once_float: assert property (p_once_float) else $error("pin driven in test mode");
  property p_dir; runOk && busActive && !holdGranted |=> xcvrDirectionOut == $past(busWrite);
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong for access");
  property p_en_turn; xcvrDirectionOe && $changed(xcvrDirectionOut) |-> xcvrEnableNOut; endproperty
  a_en_turn: assert property (p_en_turn) else $error("enable low while turning");
  property p_en_access; runOk && busActive && !holdGranted ##1 resetInN && busActive
    && !holdGranted && $stable(busWrite) |=> !xcvrEnableNOut; endproperty
  a_en_access: assert property (p_en_access) else $error("enable high in access");
  property p_lower; !lowerMemSelectNOut |->
    $past(busActive && busIsMem && !busCoproc && !holdGranted); endproperty
  a_lower: assert property (p_lower) else $error("lower select without access");
  property p_np_sel; !midMemSelectNOut[3] && midMemSelectNOe[3] && !midMemSelectNOe[0] |->
    $past(busActive && busCoproc); endproperty
  a_np_sel: assert property (p_np_sel) else $error("numeric select without cycle");
endmodule

bind csx_top csx_top_props u_csx_top_props (.clk_sys, .rst_n, .resetInN, .busActive,
  .busIsMem, .busWrite, .busCoproc, .holdGranted, .lowerMemSelectNIn, .upperMemSelectNIn,
  .lowerMemSelectNOut, .lowerMemSelectNOe, .upperMemSelectNOe, .midMemSelectNOut,
  .midMemSelectNOe, .periphSelectNOe, .periphSel5OrAddrBit1Oe, .periphSel6OrAddrBit2Oe,
  .xcvrDirectionOut, .xcvrDirectionOe, .xcvrEnableNOut, .xcvrEnableNOe, .onceModeActive);
`default_nettype wire

// *** dv/csx_top_tb_top.sv ***
// self-checking bench for csx_top: random accesses, hold, enhanced mode, strap
// assumes the checker binds itself and csx_far_side stands on the pins
`timescale 1ns/1ps
`default_nettype none
module csx_top_tb_top;
  logic        clk_sys, rst_n, resetInN, busActive, busIsMem, busIsIo, busWrite, busCoproc;
  logic        holdGranted, cfgLoad, cfgPeriphInMem, cfgSel5Latched, cfgSel6Latched, cfgEnhanced;
  logic [19:0] busAddr;
  logic [3:0]  cfgLowerSize, cfgUpperSize, midMemSelectNIn, midMemSelectNOut, midMemSelectNOe;
  logic [6:0]  cfgMidBase;
  logic [2:0]  cfgMidSize;
  logic [9:0]  cfgPeriphBase;
  logic        lowerMemSelectNIn, lowerMemSelectNOut, lowerMemSelectNOe, upperMemSelectNIn;
  logic        upperMemSelectNOut, upperMemSelectNOe, periphSel5OrAddrBit1Out;
  logic        periphSel5OrAddrBit1Oe, periphSel6OrAddrBit2Out, periphSel6OrAddrBit2Oe;
  logic        xcvrDirectionOut, xcvrDirectionOe, xcvrEnableNOut, xcvrEnableNOe;
  logic        coprocXferRequest, coprocError, onceModeActive;
  logic [4:0]  periphSelectNOut, periphSelectNOe;
  logic        strapLow, coprocReqLvl, coprocErrN, mark, hit;
  logic [1:0]  lastA;
  logic [31:0] r;
  logic [13:0] seen;
  logic [13:0] expQ[$];
  logic [19:0] base [8] = '{20'h00000, 20'hfe000, 20'h10000, 20'h41000, 20'h41000,
                            20'h80000, 20'h0f000, 20'hfc000};
  int          fail_count, n_tests;
  integer      seed;

  csx_top u_csx_top (.clk_sys, .rst_n, .resetInN, .busActive, .busIsMem, .busIsIo, .busWrite,
    .busCoproc, .busAddr, .holdGranted, .cfgLoad, .cfgLowerSize, .cfgUpperSize, .cfgMidBase,
    .cfgMidSize, .cfgPeriphBase, .cfgPeriphInMem, .cfgSel5Latched, .cfgSel6Latched, .cfgEnhanced,
    .lowerMemSelectNIn, .lowerMemSelectNOut, .lowerMemSelectNOe, .upperMemSelectNIn,
    .upperMemSelectNOut, .upperMemSelectNOe, .midMemSelectNIn, .midMemSelectNOut,
    .midMemSelectNOe, .periphSelectNOut, .periphSelectNOe, .periphSel5OrAddrBit1Out,
    .periphSel5OrAddrBit1Oe, .periphSel6OrAddrBit2Out, .periphSel6OrAddrBit2Oe,
    .xcvrDirectionOut, .xcvrDirectionOe, .xcvrEnableNOut, .xcvrEnableNOe, .coprocXferRequest,
    .coprocError, .onceModeActive);
  csx_far_side u_csx_far_side (.strapLow, .coprocReqLvl, .coprocErrN,
    .lowerOut(lowerMemSelectNOut), .lowerOe(lowerMemSelectNOe), .upperOut(upperMemSelectNOut),
    .upperOe(upperMemSelectNOe), .midOut(midMemSelectNOut), .midOe(midMemSelectNOe),
    .lowerPin(lowerMemSelectNIn), .upperPin(upperMemSelectNIn), .midPin(midMemSelectNIn));

  // pin levels as the board sees them; a released select reads high
  assign seen = {lowerMemSelectNOut | !lowerMemSelectNOe, upperMemSelectNOut | !upperMemSelectNOe,
    midMemSelectNOut | ~midMemSelectNOe, periphSelectNOut | ~periphSelectNOe,
    periphSel5OrAddrBit1Out | !periphSel5OrAddrBit1Oe,
    periphSel6OrAddrBit2Out | !periphSel6OrAddrBit2Oe, xcvrDirectionOut & xcvrDirectionOe};

  // 250 MHz clock
  always #2 clk_sys = !clk_sys;

  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("counts: %0d compares, %0d mismatches", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // expected pins one edge after an access; lastA mirrors the address latch
  function automatic logic [13:0] expv(input logic [19:0] a, input logic m, w, cp, h);
    logic [13:0] e;
    int          k;
    int          mb;
    logic [3:0]  lc;
    e = 14'h3ffe;
    lc = (cfgLowerSize > csx_pkg::LOW_UP_CODE_MAX) ? csx_pkg::LOW_UP_CODE_MAX : cfgLowerSize;
    mb = int'(cfgMidBase) << 13;
    k = int'(a[9:7]);
    if (!h) lastA = a[2:1];
    e[2] = !cfgSel5Latched | lastA[0];
    e[1] = !cfgSel6Latched | lastA[1];
    if (h) return e;
    e[0] = w;
    if (cp) begin
      e[11] = !cfgEnhanced;
      return e;
    end
    if (m && int'(a) < (32'h400 << lc)) e[13] = 1'b0;
    if (m && int'(a) >= 32'h100000 - (32'h400 << cfgUpperSize)) e[12] = 1'b0;
    if (m && int'(a) >= mb && int'(a) < mb + (32'h2000 << cfgMidSize))
      e[8 + ((int'(a) >> (11 + cfgMidSize)) & 3)] = 1'b0;
    if (cfgPeriphInMem ? (m && a[19:10] == cfgPeriphBase) : (!m && a[15:10] == cfgPeriphBase[5:0]))
    begin
      if (k < 5) e[3 + k] = 1'b0;
      if (k == 5 && !cfgSel5Latched) e[2] = 1'b0;
      if (k == 6 && !cfgSel6Latched) e[1] = 1'b0;
    end
    return e;
  endfunction

  task automatic acc(input logic [19:0] a, input logic m, w, cp, h);
    @(posedge clk_sys);
    #1;
    {busActive, busAddr, busIsMem, busIsIo, busWrite, busCoproc, holdGranted} = {1'b1, a, m, !m, w, cp, h};
    mark = 1'b1;
    expQ.push_back(expv(a, m, w, cp, h));
  endtask

  task automatic idle(input int n);
    @(posedge clk_sys);
    #1;
    {busActive, holdGranted, mark} = 3'h0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic cfg(input logic [3:0] l, u, input logic pm, s5, en);
    {cfgLowerSize, cfgUpperSize, cfgPeriphInMem, cfgSel5Latched} = {l, u, pm, s5};
    {cfgSel6Latched, cfgEnhanced, cfgLoad} = {!s5, en, 1'b1};
    @(posedge clk_sys);
    #1;
    cfgLoad = 1'b0;
  endtask

  // scoreboard: the oldest note is due one edge after its access was shown
  always @(posedge clk_sys) begin
    hit = mark;
    #2;
    if (hit && expQ.size() > 0) check(seen, expQ.pop_front());
  end

  // cut a hang well past the expected run of under 2000 cycles
  initial begin
    #40000;
    fail_count++;
    test_done();
  end

  initial begin
    {clk_sys, rst_n, busActive, busIsMem, busIsIo, busWrite, busCoproc, busAddr, holdGranted,
     cfgLoad, cfgPeriphInMem, cfgSel5Latched, cfgEnhanced, cfgLowerSize, cfgUpperSize, strapLow,
     mark, lastA} = '0;
    {resetInN, cfgSel6Latched, coprocReqLvl, coprocErrN} = 4'hf;
    {cfgMidBase, cfgMidSize, cfgPeriphBase} = {7'h08, 3'h1, 10'h104};
    seed = 32'ha20a;
    repeat (12) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    idle(3);
    // back-to-back random accesses over every region, hold mixed in
    for (int p = 0; p < 3; p++) begin
      cfg(p == 2 ? 4'hf : 4'h2, p == 2 ? 4'h0 : 4'h3, p != 1, p == 1, 1'b0);
      for (int i = 0; i < 80; i++) begin
        r = $random(seed);
        acc(base[r[2:0]] + {6'h00, r[25:12] >> {r[27:26], 1'b0}}, r[29], r[28], 1'b0,
            r[31] & r[30] & (i > 0));
      end
      idle(2);
      $display("test random pass %0d done", p);
    end
    // enhanced mode: coprocessor handshake pins and numeric select
    cfg(4'h2, 4'h3, 1'b1, 1'b0, 1'b1);
    coprocErrN = 1'b0;
    idle(3);
    check(coprocXferRequest, 1'b1);
    check(coprocError, 1'b1);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      acc(r[19:0], 1'b0, r[20], 1'b1, r[21] & r[22]);
    end
    {coprocReqLvl, coprocErrN} = 2'b01;
    idle(3);
    check(coprocXferRequest, 1'b0);
    check(coprocError, 1'b0);
    $display("test enhanced done");
    // reset pin pulses, first with both straps pulled low
    for (int s = 1; s >= 0; s--) begin
      {strapLow, resetInN} = {s[0], 1'b0};
      idle(4);
      resetInN = 1'b1;
      idle(3);
      check(onceModeActive, s[0]);
      check(lowerMemSelectNOe, !s[0]);
    end
    $display("test strap done");
    test_done();
  end
endmodule
`default_nettype wire

// *** shared/csx_pkg.sv ***
// constants for the chip select and transceiver control block
// assumes one 250 MHz clock and a 20-bit physical bus address
package csx_pkg;

  // address field widths
  localparam int ADDR_W      = 20;
  localparam int KB_SHIFT    = 10;  // 1K granule for lower, upper and peripheral
  localparam int KB_W        = 10;  // address bits 19..10
  localparam int MID_SHIFT   = 13;  // 8K granule for the mid-range region
  localparam int MID_W       = 7;   // address bits 19..13
  localparam int MID_SUB_SH  = 11;  // quarter of the smallest mid-range block
  localparam int IO_KB_W     = 6;   // 64K I/O space, bits 15..10
  localparam int PER_BLK_SH  = 7;   // 128-byte block per peripheral select

  // size code limits
  localparam logic [3:0] LOW_UP_CODE_MAX = 4'h8;  // 1K shl 8 = 256K
  localparam logic [2:0] MID_CODE_MAX    = 3'h6;  // 8K shl 6 = 512K

  // select counts
  localparam int MID_N = 4;
  localparam int PER_N = 7;

  // configuration values after reset
  localparam logic [3:0] LOW_CODE_RST   = 4'h0;
  localparam logic [3:0] UP_CODE_RST    = 4'h0;
  localparam logic [6:0] MID_BASE_RST   = 7'h00;
  localparam logic [2:0] MID_CODE_RST   = 3'h0;
  localparam logic [9:0] PER_BASE_RST   = 10'h000;
  localparam logic       PER_MEM_RST    = 1'b0;
  localparam logic       PER_LATCH_RST  = 1'b0;
  localparam logic       ENHANCED_RST   = 1'b0;

  // transceiver enable sequence while the reset pin is low
  typedef enum logic [1:0] {
    RST_RUN   = 2'b00,
    RST_DRIVE = 2'b01,
    RST_FLOAT = 2'b10
  } csx_rst_t;

endpackage
